// file: mfic_consts.svh
// Constants for the multi-function input controller
`ifndef MFIC_CONSTS_SVH
`define MFIC_CONSTS_SVH

`define OFS_CTRL      12'h000
`define OFS_EDGES     12'h004
`define OFS_ON_VAL    12'h008
`define OFS_OFF_VAL   12'h00C
`define OFS_DELAY     12'h010
`define OFS_STATUS    12'h014

`define EDGES_RST     7'h01
`define EDGES_MIN     7'h01
`define ON_RST        7'h19
`define OFF_RST       7'h4B
`define PCT_MAX       7'h64
`define DELAY_RST     10'h001
`define DELAY_MIN     10'h001
`define DELAY_MAX     10'h3E7

`define ADC_FULL      12'hFFF
`define ADC_LIVE_ZERO 12'h333
`define PCT_DIV       20'h00064

`define SEC_NS        1000000000
`define CLK_PERIOD_NS 10
`define BLINK_NS      250000000

`endif

// file: mfic_pkg.sv
// Types shared by the multi-function input controller
package mfic_pkg;

  typedef enum logic [2:0] {
    FN_OFF      = 3'h0,
    FN_ROT      = 3'h1,
    FN_SLOW     = 3'h2,
    FN_JOG_FWD  = 3'h3,
    FN_JOG_REV  = 3'h4,
    FN_AUTOSET  = 3'h5,
    FN_ANA_ZERO = 3'h6,
    FN_ANA_LIVE = 3'h7
  } func_t;

  typedef enum logic [1:0] {
    SRC_NONE   = 2'h0,
    SRC_PANEL  = 2'h1,
    SRC_REMOTE = 2'h2,
    SRC_SERIAL = 2'h3
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_STANDBY = 3'b010,
    ST_RUN     = 3'b100
  } state_t;

  typedef struct packed {
    src_t  src;
    logic  jog_rev_en;
    logic  jog_fwd_en;
    func_t func;
  } ctrl_t;

  typedef struct packed {
    logic       din;
    logic       jog_rev;
    logic       jog_fwd;
    logic       running;
    logic       standby;
    logic [6:0] edge_cnt;
  } status_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// file: persist_timer.sv
// Persistence timer: pulses once a condition has held for a number of seconds
`timescale 1ns/1ps
`include "mfic_consts.svh"

module persist_timer #(
  parameter int TICK_CYCLES = `SEC_NS / `CLK_PERIOD_NS
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       cond,
  input  wire logic [9:0] delay_s,
  output logic            expired
);

  logic [31:0] presc_reg;
  logic [9:0]  sec_reg;
  logic        fired_reg;

  // Prescaler and seconds counter, both restart when the condition lapses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc_reg <= 32'h0;
      sec_reg   <= 10'h0;
      fired_reg <= 1'b0;
      expired   <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (!cond) begin
        presc_reg <= 32'h0; // RQ21
        sec_reg   <= 10'h0; // RQ21
        fired_reg <= 1'b0;
      end else if (sec_reg >= delay_s) begin
        if (!fired_reg) begin
          expired   <= 1'b1;
          fired_reg <= 1'b1;
        end
      end else if (presc_reg == 32'(TICK_CYCLES - 1)) begin
        presc_reg <= 32'h0;
        sec_reg   <= sec_reg + 10'h1;
      end else begin
        presc_reg <= presc_reg + 32'h1;
      end
    end
  end

endmodule // persist_timer

// file: multi_function_input_control.sv
// Multi-function input controller with APB register slave
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mfic_consts.svh"

// Operation
// RQ1 - Function selector: off, five digital uses, two analogue start/stop ranges
// RQ2 - Rotation sensor use ends braking when counted edges reach configured count
// RQ3 - Slow speed use ends slow speed when counted edges reach configured count
// RQ4 - JOG forward runs while input high, when selected and separately enabled
// RQ5 - JOG reverse runs while input high, when selected and separately enabled
// RQ6 - Auto set starts on each rising input edge, only at full voltage
// RQ7 - Edge count accepts 1 to 100, default 1
// RQ8 - Edge counter counts both rising and falling transitions
// RQ9 - Code 6 uses span from zero, code 7 a live-zero span
// RQ10 - Analogue start/stop works only with remote or serial control source
// RQ11 - After start command, start when reference below on-threshold longer than delay
// RQ12 - Stop when reference above off-threshold longer than delay
// RQ13 - On-threshold at or above off-threshold inverts both comparisons
// RQ14 - Analogue start only after a valid remote or serial start command
// RQ15 - Start/stop indicator blinks while in standby awaiting analogue start
// RQ16 - Remote or serial stop command always stops the motor
// RQ17 - On-threshold 0 to 100 percent, default 25, mapped linearly onto span
// RQ18 - Off-threshold 0 to 100 percent, default 75, mapped the same way
// RQ19 - Persistence delay 1 to 999 seconds, default one second
// RQ20 - Edge counter clears at the start of each braking or slow phase
// RQ21 - Persistence timer restarts whenever its condition lapses early
module multi_function_input_control #(
  parameter int TICK_CYCLES  = `SEC_NS / `CLK_PERIOD_NS,
  parameter int BLINK_CYCLES = `BLINK_NS / `CLK_PERIOD_NS
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire mfic_pkg::apb_req_t apb_req,
  output mfic_pkg::apb_rsp_t     apb_rsp,
  input  wire logic              din_pin,
  input  wire logic [11:0]       adc_value,
  input  wire logic              braking_active,
  input  wire logic              slow_active,
  input  wire logic              full_voltage,
  input  wire logic              start_cmd,
  input  wire logic              stop_cmd,
  output logic                   brake_done,
  output logic                   slow_done,
  output logic                   jog_fwd,
  output logic                   jog_rev,
  output logic                   autoset_start,
  output logic                   motor_start,
  output logic                   motor_stop,
  output logic                   led_blink
);
  import mfic_pkg::*;

  ctrl_t       ctrl_reg;
  logic [6:0]  edges_reg, on_reg, off_reg, edge_cnt_reg;
  logic [9:0]  delay_reg;
  state_t      state_reg, state_next;
  logic        count_done_reg, din_meta, din_sync, din_prev, brake_prev, slow_prev;
  logic [31:0] blink_reg, rd_data;
  logic        din_edge, din_rise, phase_start, counting, count_hit;
  logic        analog_mode, src_ok, live_zero, inverted;
  logic [11:0] on_thr, off_thr;
  logic        start_cond, stop_cond, on_expired, off_expired;
  logic        apb_access, apb_commit, rd_err, wr_err;
  status_t     status;

  // Maps a whole percentage onto the selected input span
  function automatic logic [11:0] pct_to_level(input logic [6:0] pct, input logic live);
    logic [11:0] base;
    logic [11:0] span;
    logic [19:0] prod;
    base = live ? `ADC_LIVE_ZERO : 12'h000;
    span = live ? (`ADC_FULL - `ADC_LIVE_ZERO) : `ADC_FULL;
    prod = 20'(pct) * 20'(span);
    return base + 12'(prod / `PCT_DIV);
  endfunction

  // Checks a percentage write value
  function automatic logic pct_bad(input logic [31:0] v);
    return v > 32'(`PCT_MAX);
  endfunction

  // Two-flop synchroniser, then a history flop for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
      din_prev <= 1'b0;
    end else if (ce) begin
      din_meta <= din_pin;
      din_sync <= din_meta;
      din_prev <= din_sync;
    end
  end

  // Phase histories for start detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brake_prev <= 1'b0;
      slow_prev  <= 1'b0;
    end else if (ce) begin
      brake_prev <= braking_active;
      slow_prev  <= slow_active;
    end
  end

  // Digital use decoding
  assign din_edge    = din_sync ^ din_prev; // RQ8
  assign din_rise    = din_sync & ~din_prev;
  assign phase_start = (ctrl_reg.func == FN_ROT && braking_active && !brake_prev) ||
                       (ctrl_reg.func == FN_SLOW && slow_active && !slow_prev);
  assign counting    = (ctrl_reg.func == FN_ROT && braking_active) ||
                       (ctrl_reg.func == FN_SLOW && slow_active);
  assign count_hit   = counting && din_edge && !count_done_reg && !phase_start &&
                       (edge_cnt_reg + 7'h01 >= edges_reg);

  // Edge counter for rotation sensor and slow speed phases
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_cnt_reg   <= 7'h00;
      count_done_reg <= 1'b0;
    end else if (ce) begin
      if (phase_start) begin
        edge_cnt_reg   <= 7'h00; // RQ20
        count_done_reg <= 1'b0;
      end else if (counting && din_edge && !count_done_reg) begin
        edge_cnt_reg <= edge_cnt_reg + 7'h01; // RQ8
        if (count_hit) begin
          count_done_reg <= 1'b1;
        end
      end
    end
  end

  // Digital use outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brake_done    <= 1'b0;
      slow_done     <= 1'b0;
      jog_fwd       <= 1'b0;
      jog_rev       <= 1'b0;
      autoset_start <= 1'b0;
    end else if (ce) begin
      brake_done    <= count_hit && ctrl_reg.func == FN_ROT; // RQ2
      slow_done     <= count_hit && ctrl_reg.func == FN_SLOW; // RQ3
      jog_fwd       <= ctrl_reg.func == FN_JOG_FWD && ctrl_reg.jog_fwd_en && din_sync; // RQ4
      jog_rev       <= ctrl_reg.func == FN_JOG_REV && ctrl_reg.jog_rev_en && din_sync; // RQ5
      autoset_start <= ctrl_reg.func == FN_AUTOSET && din_rise && full_voltage; // RQ6
    end
  end

  // Analogue thresholds and comparisons
  assign analog_mode = ctrl_reg.func == FN_ANA_ZERO || ctrl_reg.func == FN_ANA_LIVE; // RQ1
  assign live_zero   = ctrl_reg.func == FN_ANA_LIVE; // RQ9
  assign src_ok      = ctrl_reg.src == SRC_REMOTE || ctrl_reg.src == SRC_SERIAL; // RQ10
  assign on_thr      = pct_to_level(on_reg, live_zero); // RQ17
  assign off_thr     = pct_to_level(off_reg, live_zero); // RQ18
  assign inverted    = on_reg >= off_reg; // RQ13
  assign start_cond  = inverted ? (adc_value > on_thr) : (adc_value < on_thr); // RQ11
  assign stop_cond   = inverted ? (adc_value < off_thr) : (adc_value > off_thr); // RQ12

  persist_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_on_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cond    (start_cond && state_reg == ST_STANDBY),
    .delay_s (delay_reg),
    .expired (on_expired)
  );

  persist_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_off_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cond    (stop_cond && state_reg == ST_RUN),
    .delay_s (delay_reg),
    .expired (off_expired)
  );

  // Analogue start/stop sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_cmd) begin
          state_next = ST_STANDBY; // RQ14
        end
      end
      ST_STANDBY: begin
        if (stop_cmd) begin
          state_next = ST_IDLE;
        end else if (on_expired) begin
          state_next = ST_RUN; // RQ11
        end
      end
      ST_RUN: begin
        if (stop_cmd || off_expired) begin
          state_next = ST_IDLE; // RQ16
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!analog_mode || !src_ok) begin
      state_next = ST_IDLE; // RQ10
    end
  end

  // State register with start and stop pulses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      motor_start <= 1'b0;
      motor_stop  <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      motor_start <= state_reg == ST_STANDBY && state_next == ST_RUN; // RQ14
      motor_stop  <= state_reg == ST_RUN && state_next != ST_RUN; // RQ12 RQ16
    end
  end

  // Indicator blinks only in standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blink_reg <= 32'h0;
      led_blink <= 1'b0;
    end else if (ce) begin
      if (state_next != ST_STANDBY) begin
        blink_reg <= 32'h0;
        led_blink <= 1'b0; // RQ15
      end else if (blink_reg == 32'(BLINK_CYCLES - 1)) begin
        blink_reg <= 32'h0;
        led_blink <= ~led_blink; // RQ15
      end else begin
        blink_reg <= blink_reg + 32'h1;
        if (state_reg != ST_STANDBY) begin
          led_blink <= 1'b1;
        end
      end
    end
  end

  // Register read view
  assign status = '{din: din_sync, jog_rev: jog_rev, jog_fwd: jog_fwd,
                    running: state_reg == ST_RUN, standby: state_reg == ST_STANDBY,
                    edge_cnt: edge_cnt_reg};

  // Address decode for reads
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (apb_req.paddr == `OFS_CTRL) begin
      rd_data = 32'(ctrl_reg);
    end else if (apb_req.paddr == `OFS_EDGES) begin
      rd_data = 32'(edges_reg);
    end else if (apb_req.paddr == `OFS_ON_VAL) begin
      rd_data = 32'(on_reg);
    end else if (apb_req.paddr == `OFS_OFF_VAL) begin
      rd_data = 32'(off_reg);
    end else if (apb_req.paddr == `OFS_DELAY) begin
      rd_data = 32'(delay_reg);
    end else if (apb_req.paddr == `OFS_STATUS) begin
      rd_data = 32'(status);
    end else begin
      rd_err = 1'b1;
    end
  end

  // Address decode and range checks for writes
  always_comb begin
    wr_err = 1'b0;
    if (apb_req.paddr == `OFS_CTRL) begin
      wr_err = apb_req.pwdata[6:5] == SRC_NONE;
    end else if (apb_req.paddr == `OFS_EDGES) begin
      wr_err = pct_bad(apb_req.pwdata) || apb_req.pwdata < 32'(`EDGES_MIN); // RQ7
    end else if (apb_req.paddr == `OFS_ON_VAL || apb_req.paddr == `OFS_OFF_VAL) begin
      wr_err = pct_bad(apb_req.pwdata); // RQ17 RQ18
    end else if (apb_req.paddr == `OFS_DELAY) begin
      wr_err = apb_req.pwdata > 32'(`DELAY_MAX) ||
               apb_req.pwdata < 32'(`DELAY_MIN); // RQ19
    end else begin
      wr_err = 1'b1;
    end
  end

  assign apb_access = apb_req.psel && apb_req.penable;
  assign apb_commit = apb_access && apb_rsp.pready;

  // APB answer: one wait cycle, then pready with data and error
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      apb_rsp <= '0;
    end else if (ce) begin
      apb_rsp.pready  <= apb_access && !apb_rsp.pready;
      apb_rsp.pslverr <= apb_access && !apb_rsp.pready &&
                         (apb_req.pwrite ? wr_err : rd_err);
      if (apb_access && !apb_rsp.pready && !apb_req.pwrite) begin
        apb_rsp.prdata <= rd_data;
      end
    end
  end

  // Writable registers take effect at the completing edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= '{src: SRC_PANEL, jog_rev_en: 1'b0, jog_fwd_en: 1'b0, func: FN_OFF};
      edges_reg <= `EDGES_RST; // RQ7
      on_reg    <= `ON_RST; // RQ17
      off_reg   <= `OFF_RST; // RQ18
      delay_reg <= `DELAY_RST; // RQ19
    end else if (ce && apb_commit && apb_req.pwrite && !wr_err) begin
      if (apb_req.paddr == `OFS_CTRL) begin
        ctrl_reg <= ctrl_t'(apb_req.pwdata[6:0]); // RQ1
      end else if (apb_req.paddr == `OFS_EDGES) begin
        edges_reg <= apb_req.pwdata[6:0];
      end else if (apb_req.paddr == `OFS_ON_VAL) begin
        on_reg <= apb_req.pwdata[6:0];
      end else if (apb_req.paddr == `OFS_OFF_VAL) begin
        off_reg <= apb_req.pwdata[6:0];
      end else if (apb_req.paddr == `OFS_DELAY) begin
        delay_reg <= apb_req.pwdata[9:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);
  // An edge that completes the count, outside the cycle that opens a phase
  sequence edge_hits_count;
    counting && din_edge && !count_done_reg && !phase_start &&
    (edge_cnt_reg + 7'h01 >= edges_reg);
  endsequence

  chk_brake_end_count: assert property ( // RQ2
    edge_hits_count and (ctrl_reg.func == FN_ROT) |=> brake_done)
    else $error("brake end missed at edge count");
  chk_slow_end_count: assert property ( // RQ3
    slow_done |-> $past(ctrl_reg.func) == FN_SLOW && count_done_reg)
    else $error("slow speed end without count");
  chk_jog_fwd_level: assert property ( // RQ4
    jog_fwd |-> $past(ctrl_reg.jog_fwd_en) && $past(din_sync))
    else $error("jog forward without high input");
  chk_jog_rev_level: assert property ( // RQ5
    ctrl_reg.func == FN_JOG_REV && ctrl_reg.jog_rev_en && din_sync |=> jog_rev)
    else $error("jog reverse not following input");
  chk_autoset_gate: assert property ( // RQ6
    autoset_start |-> ($past(full_voltage) && $past(ctrl_reg.func) == FN_AUTOSET) ##1 !autoset_start)
    else $error("auto set outside full voltage");
  chk_edges_range: assert property (edges_reg >= `EDGES_MIN && edges_reg <= `PCT_MAX) // RQ7
    else $error("edge count out of range");
  chk_panel_idle: assert property (ctrl_reg.src == SRC_PANEL |=> state_reg == ST_IDLE) // RQ10
    else $error("analogue control with panel source");
  chk_start_standby: assert property ( // RQ14
    motor_start |-> $past(state_reg) == ST_STANDBY && state_reg == ST_RUN)
    else $error("analogue start without standby");
  chk_stop_cmd: assert property ( // RQ16
    stop_cmd && state_reg == ST_RUN |=> motor_stop && state_reg == ST_IDLE)
    else $error("stop command ignored");
  chk_led_standby: assert property (led_blink |-> state_reg == ST_STANDBY) // RQ15
    else $error("indicator blinking outside standby");
  chk_delay_range: assert property (delay_reg >= `DELAY_MIN && delay_reg <= `DELAY_MAX) // RQ19
    else $error("delay out of range");

endmodule // multi_function_input_control

// file: ext_signal_model.sv
// Far-side model: external switch or sensor on the pin and a process reference
`timescale 1ns/1ps

module ext_signal_model (
  input  wire logic        ref_clk,
  output logic             din_pin,
  output logic [11:0]      adc_value
);
  // Idle state: switch open, reference at zero
  initial begin
    din_pin   = 1'b0;
    adc_value = 12'h000;
  end

  // Sensor edges: each one inverts the pin after gap clock cycles
  task automatic edges(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge ref_clk);
      din_pin <= ~din_pin;
    end
  endtask

  // Switch held at a level
  task automatic level(input logic v);
    @(posedge ref_clk);
    din_pin <= v;
  endtask

  // Process signal moves to a new value
  task automatic set_ref(input logic [11:0] v);
    @(posedge ref_clk);
    adc_value <= v;
  endtask
endmodule // ext_signal_model

// file: multi_function_input_control_tb.sv
// Self-checking testbench of the multi-function input controller
`timescale 1ns/1ps
`include "mfic_consts.svh"

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module multi_function_input_control_tb;
  import mfic_pkg::*;

  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;

  logic         ref_clk, rst, ce, din_pin, braking_active, slow_active, full_voltage;
  logic         start_cmd, stop_cmd, brake_done, slow_done, jog_fwd, jog_rev;
  logic         autoset_start, motor_start, motor_stop, led_blink, lb, e;
  logic [11:0]  adc_value;
  logic [31:0]  r;
  apb_req_t     req;
  apb_rsp_t     rsp;
  int           n_errors, compares, nb, ns, na, nst, nsp, nbl;
  row_t         rows[14] = '{
    '{0, `OFS_CTRL, 0, 32'h20, 0}, '{0, `OFS_EDGES, 0, 32'h01, 0},
    '{0, `OFS_ON_VAL, 0, 32'h19, 0}, '{0, `OFS_OFF_VAL, 0, 32'h4B, 0},
    '{0, `OFS_DELAY, 0, 32'h01, 0}, '{0, `OFS_STATUS, 0, 32'h00, 0},
    '{1, `OFS_EDGES, 32'h00, 0, 1}, '{1, `OFS_EDGES, 32'h65, 0, 1},
    '{1, `OFS_DELAY, 32'h3E8, 0, 1}, '{1, 12'h018, 32'h01, 0, 1},
    '{1, `OFS_EDGES, 32'h64, 0, 0}, '{0, `OFS_EDGES, 0, 32'h64, 0},
    '{1, `OFS_CTRL, 32'h06, 0, 1}, '{1, `OFS_ON_VAL, 32'h65, 0, 1}};

  multi_function_input_control #(.TICK_CYCLES(10), .BLINK_CYCLES(4))
    multi_function_input_control_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(rsp),
    .din_pin(din_pin), .adc_value(adc_value), .braking_active(braking_active),
    .slow_active(slow_active), .full_voltage(full_voltage), .start_cmd(start_cmd),
    .stop_cmd(stop_cmd), .brake_done(brake_done), .slow_done(slow_done), .jog_fwd(jog_fwd),
    .jog_rev(jog_rev), .autoset_start(autoset_start), .motor_start(motor_start),
    .motor_stop(motor_stop), .led_blink(led_blink));

  ext_signal_model ext_signal_model_i (.ref_clk(ref_clk), .din_pin(din_pin),
    .adc_value(adc_value));

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Pulse and toggle counters, sampled away from the active edge
  always @(negedge ref_clk) begin
    nb += brake_done; ns += slow_done; na += autoset_start;
    nst += motor_start; nsp += motor_stop;
    if (led_blink !== lb) nbl++;
    lb = led_blink;
  end

  // APB master: setup, access held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
    end while (rsp.pready !== 1'b1 && t < 20);
    // Answer taken at the completing edge, request released right after it
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (t >= 20) n_errors++;
  endtask

  // Register write expected to be accepted
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK("write_err", 1'b0, e)
  endtask

  task w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One-cycle remote start or stop command
  task cmd(input bit st);
    @(posedge ref_clk);
    if (st) start_cmd <= 1'b1;
    else stop_cmd <= 1'b1;
    @(posedge ref_clk);
    start_cmd <= 1'b0;
    stop_cmd  <= 1'b0;
  endtask

  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung handshake or sequence
  initial begin
    #500000;
    n_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    rst = 1'b1; req = '0; braking_active = 0; slow_active = 0; full_voltage = 0;
    start_cmd = 0; stop_cmd = 0; ce = 1'b1; lb = 1'b0;
    w(12);
    rst <= 1'b0;
    `CHK("rst_out", 3'b000, {jog_fwd, jog_rev, led_blink})
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK("apb_err", rows[i].e, e)
      if (!rows[i].w) `CHK("apb_rd", rows[i].x, r)
    end
    // Edge counting for braking end and slow speed end
    for (int f = 1; f <= 2; f++) begin
      wr(`OFS_CTRL, 32'h20 | f);
      wr(`OFS_EDGES, 32'h03);
      for (int p = 1; p <= 2; p++) begin
        @(posedge ref_clk);
        if (f == 1) braking_active <= 1'b1;
        else slow_active <= 1'b1;
        w(4);
        ext_signal_model_i.edges(2, 6);
        w(8);
        `CHK("done_early", p - 1, (f == 1) ? nb : ns)
        ext_signal_model_i.edges(p == 1 ? 5 : 1, 6);
        w(8);
        `CHK("done_cnt", p, (f == 1) ? nb : ns)
        braking_active <= 1'b0;
        slow_active    <= 1'b0;
      end
    end
    // JOG levels, with and without the enable
    for (int j = 0; j < 2; j++) begin
      ext_signal_model_i.level(1'b0);
      wr(`OFS_CTRL, 32'h20 | (3 + j));
      ext_signal_model_i.level(1'b1);
      w(8);
      `CHK("jog_off", 2'b00, {jog_rev, jog_fwd})
      wr(`OFS_CTRL, 32'h20 | (3 + j) | (8 << j));
      w(8);
      `CHK("jog_on", 2'b01 << j, {jog_rev, jog_fwd})
      // Clock enable low freezes the level output although the pin drops
      ce <= 1'b0;
      ext_signal_model_i.level(1'b0);
      w(8);
      `CHK("jog_frozen", 2'b01 << j, {jog_rev, jog_fwd})
      ce <= 1'b1;
      w(8);
      `CHK("jog_low", 2'b00, {jog_rev, jog_fwd})
    end
    // Auto set only at full voltage, on rising edges
    wr(`OFS_CTRL, 32'h25);
    ext_signal_model_i.level(1'b1);
    w(8);
    ext_signal_model_i.level(1'b0);
    full_voltage <= 1'b1;
    ext_signal_model_i.level(1'b1);
    w(8);
    ext_signal_model_i.level(1'b0);
    w(8);
    `CHK("autoset", 1, na)
    // Analogue start/stop, zero-based span
    wr(`OFS_CTRL, 32'h46);
    w(40);
    `CHK("no_cmd", 0, nst)
    cmd(1);
    w(30);
    `CHK("ana_start", 1, nst)
    `CHK("blink", 1'b1, nbl > 1)
    ext_signal_model_i.set_ref(12'hFFF);
    w(30);
    `CHK("ana_stop", 1, nsp)
    ext_signal_model_i.set_ref(12'h000);
    cmd(1);
    w(30);
    cmd(0);
    w(4);
    `CHK("cmd_stop", 2'h2, {nst[0], nsp[1:0]})
    // Inverted thresholds
    wr(`OFS_ON_VAL, 32'h50);
    wr(`OFS_OFF_VAL, 32'h14);
    cmd(1);
    w(30);
    `CHK("inv_hold", 2, nst)
    ext_signal_model_i.set_ref(12'hFFF);
    w(30);
    ext_signal_model_i.set_ref(12'h000);
    w(30);
    `CHK("inv_run", 6'h1B, {nst[2:0], nsp[2:0]})
    // Panel source refuses analogue start
    wr(`OFS_CTRL, 32'h26);
    ext_signal_model_i.set_ref(12'hFFF);
    cmd(1);
    w(40);
    `CHK("panel", 3, nst)
    // Zero-based span first: 1400 lies between the two 25 percent points
    wr(`OFS_ON_VAL, 32'h19);
    wr(`OFS_OFF_VAL, 32'h4B);
    wr(`OFS_CTRL, 32'h46);
    ext_signal_model_i.set_ref(12'h578);
    cmd(1);
    w(30);
    `CHK("span0", 3, nst)
    cmd(0);
    // Live-zero span under serial control
    wr(`OFS_CTRL, 32'h67);
    cmd(1);
    w(30);
    `CHK("span_live", 4, nst)
    report_and_stop;
  end
endmodule // multi_function_input_control_tb
